// File: hw/crx_rx_storage.sv
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/100ps
module crx_rx_storage #(
  parameter int FIFO_MAX = 64
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [28:0] rx_ext_id,
  output logic [28:0] masked_ext_id,
  input wire crx_pkg::crx_match_t rx_match,
  input wire logic rx_last_word,
  output logic rx_accept,
  output logic rx_reject,
  output logic [15:0] rx_store_addr,
  output logic [63:0] buffer_locked,
  output logic dma_req,
  input wire logic dma_ack
);
  import crx_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [28:0] ext_mask;
    logic [31:0] buf_cfg;
    logic [31:0] f0_cfg;
    logic [31:0] f1_cfg;
    crx_fifo_t f0;
    crx_fifo_t f1;
    logic [6:0] irq;
    logic [63:0] ndat;
    crx_dbg_t dbg;
    logic dma_req;
    logic pend;
    crx_target_t pend_tgt;
    logic [5:0] pend_idx;
    logic [1:0] pend_dbg;
    logic [15:0] store_addr;
    logic [31:0] rdata;
  } crx_state_t;

  crx_state_t st;
  crx_state_t next_st;
  logic wr_en;
  logic rd_en;
  logic [6:0] f0_level;
  logic [6:0] f1_level;
  logic [6:0] f0_size;
  logic [6:0] f1_size;
  function automatic logic [6:0] fifo_size(input logic [31:0] cfg);
    logic [6:0] s;
    s = cfg[CFG_SIZE_LSB +: 7];
    return (s > 7'(FIFO_MAX)) ? 7'(FIFO_MAX) : s;
  endfunction : fifo_size
  function automatic logic [6:0] fifo_level(input crx_fifo_t f, input logic [6:0] sz);
    return f.full ? sz : (f.put >= f.get) ? 7'(f.put - f.get) : 7'(f.put + sz - f.get);
  endfunction : fifo_level
  function automatic logic [6:0] fifo_inc(input logic [6:0] v, input logic [6:0] sz);
    return (7'(v + 7'h01) >= sz) ? 7'h00 : 7'(v + 7'h01);
  endfunction : fifo_inc
  function automatic logic [15:0] elem_addr(input logic [31:0] cfg, input logic [2:0] code,
                                            input logic [6:0] idx);
    return 16'(cfg[CFG_SA_LSB +: 14]) + 16'(idx) * 16'(crx_elem_words(code));
  endfunction : elem_addr
  assign f0_size = fifo_size(st.f0_cfg);
  assign f1_size = fifo_size(st.f1_cfg);
  assign f0_level = fifo_level(st.f0, f0_size);
  assign f1_level = fifo_level(st.f1, f1_size);
  assign wr_en = psel && penable && pwrite && ce;
  assign rd_en = psel && !penable && !pwrite;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic dbg_slot;
    logic [1:0] dsel;
    logic [5:0] bidx;
    next_st = st;
    dbg_slot = 1'b0;
    dsel = rx_match.second_id[10:9];
    bidx = rx_match.second_id[5:0];
    rx_accept = 1'b0;
    rx_reject = 1'b0;
    // Bus read data captured in setup cycle
    if (rd_en) begin
      unique case (paddr)
        ADDR_EXT_MASK: next_st.rdata = {3'h0, st.ext_mask};
        ADDR_BUF_CFG: next_st.rdata = st.buf_cfg;
        ADDR_FIFO0_CFG: next_st.rdata = st.f0_cfg;
        ADDR_FIFO1_CFG: next_st.rdata = st.f1_cfg;
        ADDR_FIFO0_STAT: next_st.rdata = {7'h00, f0_level, 2'h0, st.f0.lost, st.f0.full,
                                          st.f0.put, st.f0.get};
        ADDR_FIFO1_STAT: next_st.rdata = {7'h00, f1_level, 2'h0, st.f1.lost, st.f1.full,
                                          st.f1.put, st.f1.get};
        ADDR_IRQ: next_st.rdata = {25'h000_0000, st.irq};
        ADDR_NDAT_LOW: next_st.rdata = st.ndat[31:0];
        ADDR_NDAT_HIGH: next_st.rdata = st.ndat[63:32];
        ADDR_DBG_STAT: next_st.rdata = {29'h0000_0000, st.dma_req, 2'(st.dbg)};
        ADDR_FIFO0_ADDR: next_st.rdata = {16'h0000,
          elem_addr(st.f0_cfg, st.buf_cfg[F0_DS_LSB +: 3], st.f0.get)};
        ADDR_FIFO1_ADDR: next_st.rdata = {16'h0000,
          elem_addr(st.f1_cfg, st.buf_cfg[F1_DS_LSB +: 3], st.f1.get)};
        default: next_st.rdata = 32'h0000_0000;
      endcase
    end
    // Register writes; hardware sets below take priority over clears
    if (wr_en) begin
      unique case (paddr)
        ADDR_EXT_MASK: next_st.ext_mask = pwdata[28:0];
        ADDR_BUF_CFG: next_st.buf_cfg = pwdata;
        ADDR_FIFO0_CFG: next_st.f0_cfg = pwdata;
        ADDR_FIFO1_CFG: next_st.f1_cfg = pwdata;
        ADDR_FIFO0_ACK: begin
          next_st.f0.get = fifo_inc(pwdata[6:0], f0_size);
          next_st.f0.full = st.f0.full && (st.f0.put == next_st.f0.get);
        end
        ADDR_FIFO1_ACK: begin
          next_st.f1.get = fifo_inc(pwdata[6:0], f1_size);
          next_st.f1.full = st.f1.full && (st.f1.put == next_st.f1.get);
        end
        ADDR_FIFO0_STAT: next_st.f0.lost = st.f0.lost & ~pwdata[15];
        ADDR_FIFO1_STAT: next_st.f1.lost = st.f1.lost & ~pwdata[15];
        ADDR_IRQ: next_st.irq = st.irq & ~pwdata[6:0];
        ADDR_NDAT_LOW: next_st.ndat[31:0] = st.ndat[31:0] & ~pwdata;
        ADDR_NDAT_HIGH: next_st.ndat[63:32] = st.ndat[63:32] & ~pwdata;
        default: ;
      endcase
    end
    // Frame verdict: choose the store location
    if (rx_match.valid && !st.pend) begin
      unique case (rx_match.target)
        CRX_TGT_FIFO0: begin
          if (st.f0.full && !st.f0_cfg[CFG_MODE_BIT]) begin
            rx_reject = 1'b1;
            next_st.f0.lost = 1'b1;
            next_st.irq[IRQ_F0_LOST] = 1'b1;
          end else begin
            rx_accept = 1'b1;
            next_st.pend = 1'b1;
            next_st.pend_tgt = CRX_TGT_FIFO0;
            next_st.store_addr = elem_addr(st.f0_cfg, st.buf_cfg[F0_DS_LSB +: 3], st.f0.put);
          end
        end
        CRX_TGT_FIFO1: begin
          if (st.f1.full && !st.f1_cfg[CFG_MODE_BIT]) begin
            rx_reject = 1'b1;
            next_st.f1.lost = 1'b1;
            next_st.irq[IRQ_F1_LOST] = 1'b1;
          end else begin
            rx_accept = 1'b1;
            next_st.pend = 1'b1;
            next_st.pend_tgt = CRX_TGT_FIFO1;
            next_st.store_addr = elem_addr(st.f1_cfg, st.buf_cfg[F1_DS_LSB +: 3], st.f1.put);
          end
        end
        default: begin
          if (dsel != 2'b00) begin
            dbg_slot = (dsel == 2'b01 && st.dbg == CRX_DBG_IDLE) ||
                       (dsel == 2'b10 && st.dbg == CRX_DBG_GOT_A) ||
                       (dsel == 2'b11 && st.dbg == CRX_DBG_GOT_AB);
            if (st.dma_req) begin
              rx_reject = 1'b1;
            end else if (dbg_slot || dsel == 2'b01) begin
              rx_accept = 1'b1;
              next_st.pend = 1'b1;
              next_st.pend_dbg = dsel;
              next_st.dbg = dbg_slot ? st.dbg : CRX_DBG_IDLE;
            end else begin
              rx_reject = 1'b1;
              next_st.dbg = CRX_DBG_IDLE;
            end
          end else if (st.ndat[bidx]) begin
            rx_reject = 1'b1;
          end else begin
            rx_accept = 1'b1;
            next_st.pend = 1'b1;
            next_st.pend_dbg = 2'b00;
          end
          next_st.pend_tgt = CRX_TGT_BUFFER;
          next_st.pend_idx = bidx;
          next_st.store_addr = elem_addr(st.buf_cfg, st.buf_cfg[BUF_DS_LSB +: 3], 7'(bidx));
        end
      endcase
    end
    // Commit once the last word is in RAM
    if (st.pend && rx_last_word) begin
      next_st.pend = 1'b0;
      unique case (st.pend_tgt)
        CRX_TGT_FIFO0: begin
          next_st.f0.get = st.f0.full ? fifo_inc(st.f0.get, f0_size) : next_st.f0.get;
          next_st.f0.put = fifo_inc(st.f0.put, f0_size);
          next_st.f0.full |= (next_st.f0.put == next_st.f0.get);
          next_st.irq[IRQ_F0_FULL] |= (next_st.f0.put == next_st.f0.get);
          next_st.irq[IRQ_F0_WM] |= (7'(f0_level + 7'h01) == st.f0_cfg[CFG_WM_LSB +: 7]);
        end
        CRX_TGT_FIFO1: begin
          next_st.f1.get = st.f1.full ? fifo_inc(st.f1.get, f1_size) : next_st.f1.get;
          next_st.f1.put = fifo_inc(st.f1.put, f1_size);
          next_st.f1.full |= (next_st.f1.put == next_st.f1.get);
          next_st.irq[IRQ_F1_FULL] |= (next_st.f1.put == next_st.f1.get);
          next_st.irq[IRQ_F1_WM] |= (7'(f1_level + 7'h01) == st.f1_cfg[CFG_WM_LSB +: 7]);
        end
        default: begin
          if (st.pend_dbg == 2'b00) begin
            next_st.ndat[st.pend_idx] = 1'b1;
            next_st.irq[IRQ_DEDICATED] = 1'b1;
          end else begin
            unique case (st.pend_dbg)
              2'b01: next_st.dbg = CRX_DBG_GOT_A;
              2'b10: next_st.dbg = CRX_DBG_GOT_AB;
              default: begin
                next_st.dbg = CRX_DBG_GOT_ABC;
                next_st.dma_req = 1'b1;
              end
            endcase
          end
        end
      endcase
    end
    if (st.dma_req && dma_ack) begin
      next_st.dma_req = 1'b0;
      next_st.dbg = CRX_DBG_IDLE;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
      st.ext_mask <= EXT_MASK_RESET;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // extended mask
  assign masked_ext_id = rx_ext_id & st.ext_mask;
  assign prdata = st.rdata;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign rx_store_addr = st.store_addr;
  assign buffer_locked = st.ndat;
  assign dma_req = st.dma_req;

  // ****************************************
  // Checks
  // ****************************************
  chk_dma_release: assert property (@(posedge clk) disable iff (rst)
    ce && st.dma_req && dma_ack |=> !dma_req && st.dbg == CRX_DBG_IDLE)
    else $error("dma request not released");
  chk_dma_after_c: assert property (@(posedge clk) disable iff (rst)
    $rose(dma_req) |-> $past(st.dbg) == CRX_DBG_GOT_AB)
    else $error("dma request without full sequence");
  chk_mask_and: assert property (@(posedge clk) disable iff (rst)
    masked_ext_id == (rx_ext_id & st.ext_mask)) else $error("mask not applied");
  chk_block_drop: assert property (@(posedge clk) disable iff (rst)
    ce && rx_match.valid && !st.pend && rx_match.target == CRX_TGT_FIFO0 && st.f0.full
    && !st.f0_cfg[CFG_MODE_BIT] |=> st.f0.lost && st.irq[IRQ_F0_LOST])
    else $error("lost not flagged");
  chk_no_block_accept: assert property (@(posedge clk) disable iff (rst)
    rx_accept && rx_match.target == CRX_TGT_FIFO0 |-> !st.f0.full || st.f0_cfg[CFG_MODE_BIT])
    else $error("accepted into blocked fifo");
  chk_lock_reject: assert property (@(posedge clk) disable iff (rst)
    rx_match.valid && !st.pend && rx_match.target == CRX_TGT_BUFFER
    && rx_match.second_id[10:9] == 2'b00 && st.ndat[rx_match.second_id[5:0]] |-> rx_reject)
    else $error("locked buffer matched");
  chk_ndat_set: assert property (@(posedge clk) disable iff (rst)
    ce && st.pend && rx_last_word && st.pend_tgt == CRX_TGT_BUFFER && st.pend_dbg == 2'b00
    |=> st.ndat[$past(st.pend_idx)] && st.irq[IRQ_DEDICATED])
    else $error("new data not set");
  chk_full_level: assert property (@(posedge clk) disable iff (rst)
    st.f0.full |-> f0_level == f0_size) else $error("full level wrong");
  chk_dbg_hold: assert property (@(posedge clk) disable iff (rst)
    dma_req && !dma_ack && rx_match.target == CRX_TGT_BUFFER
    |-> !(rx_accept && rx_match.second_id[10:9] != 2'b00))
    else $error("debug store while request");
  cov_dma: cover property (@(posedge clk) dma_req ##[1:60] dma_ack);
  cov_full: cover property (@(posedge clk) $rose(st.f0.full));
  cov_lost: cover property (@(posedge clk) $rose(st.f0.lost));
  cov_lock: cover property (@(posedge clk) rx_reject && rx_match.target == CRX_TGT_BUFFER);

endmodule : crx_rx_storage

// File: hw/crx_pkg.sv
package crx_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [11:0] ADDR_EXT_MASK = 12'h000;
  localparam logic [11:0] ADDR_BUF_CFG = 12'h004;
  localparam logic [11:0] ADDR_FIFO0_CFG = 12'h008;
  localparam logic [11:0] ADDR_FIFO1_CFG = 12'h00C;
  localparam logic [11:0] ADDR_FIFO0_STAT = 12'h010;
  localparam logic [11:0] ADDR_FIFO1_STAT = 12'h014;
  localparam logic [11:0] ADDR_FIFO0_ACK = 12'h018;
  localparam logic [11:0] ADDR_FIFO1_ACK = 12'h01C;
  localparam logic [11:0] ADDR_IRQ = 12'h020;
  localparam logic [11:0] ADDR_NDAT_LOW = 12'h024;
  localparam logic [11:0] ADDR_NDAT_HIGH = 12'h028;
  localparam logic [11:0] ADDR_DBG_STAT = 12'h02C;
  localparam logic [11:0] ADDR_FIFO0_ADDR = 12'h030;
  localparam logic [11:0] ADDR_FIFO1_ADDR = 12'h034;

  // ****************************************
  // Field layout
  // ****************************************
  // fifo cfg: [15:2] start word addr, [22:16] size, [29:23] watermark, [31] mode
  localparam int CFG_SA_LSB = 2;
  localparam int CFG_SIZE_LSB = 16;
  localparam int CFG_WM_LSB = 23;
  localparam int CFG_MODE_BIT = 31;
  // buffer cfg: [15:2] start word addr, [18:16] buffer size code, [22:20] fifo0, [26:24] fifo1
  localparam int BUF_DS_LSB = 16;
  localparam int F0_DS_LSB = 20;
  localparam int F1_DS_LSB = 24;
  // irq bits
  localparam int IRQ_F0_WM = 0;
  localparam int IRQ_F0_FULL = 1;
  localparam int IRQ_F0_LOST = 2;
  localparam int IRQ_F1_WM = 3;
  localparam int IRQ_F1_FULL = 4;
  localparam int IRQ_F1_LOST = 5;
  localparam int IRQ_DEDICATED = 6;

  localparam logic [28:0] EXT_MASK_RESET = 29'h1FFF_FFFF;
  localparam int FIFO_DEPTH_MAX = 64;
  localparam int NUM_BUFFERS = 64;
  localparam logic [2:0] FILTER_CODE_BUFFER = 3'h7;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    CRX_TGT_FIFO0,
    CRX_TGT_FIFO1,
    CRX_TGT_BUFFER
  } crx_target_t;

  typedef enum logic [1:0] {
    CRX_DBG_IDLE,
    CRX_DBG_GOT_A,
    CRX_DBG_GOT_AB,
    CRX_DBG_GOT_ABC
  } crx_dbg_t;

  // Filter verdict for one received frame, as supplied by the filter engine
  typedef struct packed {
    logic valid;
    logic is_ext;
    crx_target_t target;
    logic [2:0] code;
    logic [10:0] second_id;
  } crx_match_t;

  typedef struct packed {
    logic [6:0] put;
    logic [6:0] get;
    logic full;
    logic lost;
  } crx_fifo_t;

  // Size code to RAM words per element
  function automatic logic [4:0] crx_elem_words(input logic [2:0] code);
    unique case (code)
      3'h0: return 5'h04;
      3'h1: return 5'h05;
      3'h2: return 5'h06;
      3'h3: return 5'h07;
      3'h4: return 5'h08;
      3'h5: return 5'h0A;
      3'h6: return 5'h0E;
      3'h7: return 5'h12;
    endcase
  endfunction : crx_elem_words

endpackage : crx_pkg

// File: verif/crx_dma_model.sv
`timescale 1ns/100ps
module crx_dma_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic dma_req,
  input wire logic [7:0] ack_delay,
  output logic dma_ack
);
  logic [7:0] count;

  // ack after transfer
  // Ack is held until the request drops, so a slow device cannot miss it
  always_ff @(posedge clk) begin
    if (rst || !dma_req) begin
      count <= 8'h00;
      dma_ack <= 1'b0;
    end else if (count == ack_delay) begin
      dma_ack <= 1'b1;
    end else begin
      count <= count + 8'h01;
    end
  end
endmodule : crx_dma_model

// File: verif/tb.sv
`timescale 1ns/100ps
module tb;
  import crx_pkg::*;
  logic clk, rst, psel, penable, pwrite, rx_last_word, dma_ack, pready, pslverr;
  logic rx_accept, rx_reject, dma_req, acc;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [28:0] rx_ext_id, masked_ext_id;
  crx_match_t rx_match;
  logic [15:0] rx_store_addr, sa;
  logic [63:0] buffer_locked;
  logic [7:0] ack_delay;
  int err_count, comparisons;

  crx_rx_storage #(.FIFO_MAX(64)) dut (.clk(clk), .rst(rst), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_ext_id(rx_ext_id), .masked_ext_id(masked_ext_id),
    .rx_match(rx_match), .rx_last_word(rx_last_word), .rx_accept(rx_accept),
    .rx_reject(rx_reject), .rx_store_addr(rx_store_addr), .buffer_locked(buffer_locked),
    .dma_req(dma_req), .dma_ack(dma_ack));

  crx_dma_model dma (.clk(clk), .rst(rst), .dma_req(dma_req), .ack_delay(ack_delay),
    .dma_ack(dma_ack));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic hang(input string what);
    err_count++;
    $display("CHECK FAILED %s expected done seen timeout", what);
    wrap_up();
  endtask : hang

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    n = 0;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) hang("apb ready");
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, rd, exp);
  endtask : rchk

  // Entered just after a rising edge; last word is only sent for accepted frames
  task automatic frame(input crx_target_t t, input logic [2:0] fc, input logic [10:0] sid);
    rx_match <= '{valid: 1'b1, is_ext: 1'b1, target: t, code: fc, second_id: sid};
    rx_ext_id <= 29'h0ABC_DEF1;
    @(negedge clk);
    acc = rx_accept;
    @(posedge clk);
    rx_match <= '0;
    @(negedge clk);
    sa = rx_store_addr;
    @(posedge clk);
    rx_last_word <= acc;
    @(posedge clk);
    rx_last_word <= 1'b0;
    @(posedge clk);
  endtask : frame

  function automatic logic [31:0] fcfg(input logic [13:0] s, input logic [6:0] size,
                                       input logic [6:0] wm, input logic mode);
    return {mode, 1'b0, wm, size, s, 2'b00};
  endfunction : fcfg

  function automatic logic [31:0] st(input logic [6:0] g, input logic [6:0] p, input logic f,
                                     input logic l, input logic [6:0] lv);
    return {7'h00, lv, 2'b00, l, f, p, g};
  endfunction : st

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_mask;
    rx_ext_id <= 29'h1234_5678;
    @(posedge clk);
    chk("mask reset", {3'b000, masked_ext_id}, 32'h1234_5678);
    apb(1'b1, ADDR_EXT_MASK, 32'h0F0F_0F0F);
    chk("mask and", {3'b000, masked_ext_id}, 32'h0204_0608);
    rchk("unmapped", 12'h0FC, 32'h0000_0000);
    apb(1'b1, ADDR_EXT_MASK, 32'h1FFF_FFFF);
    $display("mask scenario finished");
  endtask : t_mask

  task automatic t_fifo_block;
    apb(1'b1, ADDR_FIFO0_CFG, fcfg(14'h0040, 7'h04, 7'h03, 1'b0));
    for (int i = 0; i < 4; i++) begin
      frame(CRX_TGT_FIFO0, 3'h1, 11'h000);
      chk("f0 store", {15'h0000, acc, sa}, 32'h0001_0040 + 32'(i * 10));
      apb(1'b0, ADDR_IRQ, 32'h0000_0000);
      chk("f0 wm", {31'h0000_0000, rd[IRQ_F0_WM]}, {31'h0000_0000, i >= 2});
    end
    rchk("f0 full", ADDR_FIFO0_STAT, st(7'h00, 7'h00, 1'b1, 1'b0, 7'h04));
    frame(CRX_TGT_FIFO0, 3'h1, 11'h000);
    chk("f0 block", {31'h0000_0000, acc}, 32'h0000_0000);
    rchk("f0 lost", ADDR_FIFO0_STAT, st(7'h00, 7'h00, 1'b1, 1'b1, 7'h04));
    rchk("f0 irq", ADDR_IRQ, 32'h0000_0007);
    apb(1'b1, ADDR_FIFO0_ACK, 32'h0000_0001);
    rchk("f0 ack", ADDR_FIFO0_STAT, st(7'h02, 7'h00, 1'b0, 1'b1, 7'h02));
    rchk("f0 elem", ADDR_FIFO0_ADDR, 32'h0000_0054);
    apb(1'b1, ADDR_FIFO0_STAT, 32'h0000_8000);
    frame(CRX_TGT_FIFO0, 3'h1, 11'h000);
    chk("f0 resume", {15'h0000, acc, sa}, 32'h0001_0040);
    rchk("f0 after", ADDR_FIFO0_STAT, st(7'h02, 7'h01, 1'b0, 1'b0, 7'h03));
    $display("blocking fifo scenario finished");
  endtask : t_fifo_block

  task automatic t_fifo_over;
    apb(1'b1, ADDR_FIFO1_CFG, fcfg(14'h0200, 7'h02, 7'h00, 1'b1));
    for (int i = 0; i < 3; i++) begin
      frame(CRX_TGT_FIFO1, 3'h2, 11'h000);
      chk("f1 store", {15'h0000, acc, sa}, 32'h0001_0200 + 32'((i % 2) * 18));
    end
    rchk("f1 over", ADDR_FIFO1_STAT, st(7'h01, 7'h01, 1'b1, 1'b0, 7'h02));
    // reader acks the overwritten element 0, so get stays at 1
    apb(1'b1, ADDR_FIFO1_ACK, 32'h0000_0000);
    rchk("f1 ack at put", ADDR_FIFO1_STAT, st(7'h01, 7'h01, 1'b1, 1'b0, 7'h02));
    apb(1'b0, ADDR_IRQ, 32'h0000_0000);
    chk("f1 irq", {30'h0, rd[IRQ_F1_LOST], rd[IRQ_F1_FULL]}, 32'h0000_0001);
    $display("overwrite fifo scenario finished");
  endtask : t_fifo_over

  task automatic t_buffer;
    frame(CRX_TGT_BUFFER, FILTER_CODE_BUFFER, 11'h025);
    chk("buf store", {15'h0000, acc, sa}, 32'h0001_0394);
    chk("buf lock", {31'h0000_0000, buffer_locked[37]}, 32'h0000_0001);
    apb(1'b0, ADDR_IRQ, 32'h0000_0000);
    chk("buf irq", {31'h0000_0000, rd[IRQ_DEDICATED]}, 32'h0000_0001);
    apb(1'b1, ADDR_IRQ, 32'h0000_0040);
    rchk("buf ndat", ADDR_NDAT_HIGH, 32'h0000_0020);
    frame(CRX_TGT_BUFFER, FILTER_CODE_BUFFER, 11'h025);
    chk("buf locked", {31'h0000_0000, acc}, 32'h0000_0000);
    apb(1'b1, ADDR_NDAT_HIGH, 32'h0000_0020);
    chk("buf unlock", buffer_locked[63:32], 32'h0000_0000);
    frame(CRX_TGT_BUFFER, FILTER_CODE_BUFFER, 11'h025);
    chk("buf again", {31'h0000_0000, acc}, 32'h0000_0001);
    apb(1'b1, ADDR_NDAT_HIGH, 32'h0000_0020);
    $display("buffer scenario finished");
  endtask : t_buffer

  task automatic t_debug;
    int n;
    apb(1'b1, ADDR_IRQ, 32'h0000_007F);
    frame(CRX_TGT_BUFFER, FILTER_CODE_BUFFER, 11'h43E);
    chk("dbg b first", {31'h0000_0000, acc}, 32'h0000_0000);
    frame(CRX_TGT_BUFFER, FILTER_CODE_BUFFER, 11'h23D);
    chk("dbg a", {15'h0000, acc, sa}, 32'h0001_03F4);
    rchk("dbg state a", ADDR_DBG_STAT, 32'h0000_0001);
    frame(CRX_TGT_BUFFER, FILTER_CODE_BUFFER, 11'h63F);
    chk("dbg c early", {31'h0000_0000, acc}, 32'h0000_0000);
    rchk("dbg restart", ADDR_DBG_STAT, 32'h0000_0000);
    for (int i = 0; i < 3; i++) begin
      frame(CRX_TGT_BUFFER, FILTER_CODE_BUFFER, {2'(i + 1), 3'b000, 6'(i + 61)});
      chk("dbg seq", {15'h0000, acc, sa}, 32'h0001_03F4 + 32'(i * 4));
    end
    chk("dma req", {31'h0000_0000, dma_req}, 32'h0000_0001);
    rchk("dbg done", ADDR_DBG_STAT, 32'h0000_0007);
    chk("dbg no ndat", {29'h0, buffer_locked[63:61]}, 32'h0000_0000);
    apb(1'b0, ADDR_IRQ, 32'h0000_0000);
    chk("dbg no irq", {31'h0000_0000, rd[IRQ_DEDICATED]}, 32'h0000_0000);
    frame(CRX_TGT_BUFFER, FILTER_CODE_BUFFER, 11'h23D);
    chk("dbg frozen", {31'h0000_0000, acc}, 32'h0000_0000);
    n = 0;
    while (dma_req === 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    if (n >= 100) hang("dma release");
    rchk("dbg rearm", ADDR_DBG_STAT, 32'h0000_0000);
    frame(CRX_TGT_BUFFER, FILTER_CODE_BUFFER, 11'h23D);
    chk("dbg next set", {31'h0000_0000, acc}, 32'h0000_0001);
    $display("debug scenario finished");
  endtask : t_debug

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    rx_ext_id = 29'h0000_0000;
    rx_match = '0;
    rx_last_word = 1'b0;
    ack_delay = 8'h28;
    err_count = 0;
    comparisons = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b1, ADDR_BUF_CFG, 32'h0750_0C00);
    t_mask();
    t_fifo_block();
    t_fifo_over();
    t_buffer();
    t_debug();
    wrap_up();
  end
endmodule : tb
